// *** logic/csu_defines.vh ***
// Purpose: constants shared by the configuration shadow/update block
// Assumes: 7-bit register addresses, 16-bit register data
// Notes: per-register maps are packed 16 bits per register, index 0 in the low word
`ifndef CSU_DEFINES_VH
`define CSU_DEFINES_VH

// serial frame layout
`define CSU_FRAME_BITS 24
`define CSU_ADDR_BITS 7
`define CSU_DATA_BITS 16
`define CSU_CMD_WRITE 1'b1
`define CSU_CMD_READ 1'b0

// register addresses
`define CSU_ADDR_FUNC_ST 7'h03
`define CSU_ADDR_CFG_FIRST 7'h11
`define CSU_ADDR_CFG_LAST 7'h1e
`define CSU_ADDR_NV_PROG 7'h1f
`define CSU_NREG 14

// field positions in the nv program register and functional status
`define CSU_NVP_CMD_BIT 0
`define CSU_NVP_UID_LSB 8
`define CSU_FST_STANDBY 0
`define CSU_FST_LOADED 1
`define CSU_FST_REFUSED 2
`define CSU_FST_NV_BUSY 3

// converter register bits
`define CSU_ADC_INDEX 1
`define CSU_ADC_REQ_BIT 0

// class maps, index 13 (leftmost) down to index 0
`define CSU_ALW_MAP {16'h70ff, 16'h01f7, 16'h0003, 16'hffff, 16'hffff, 16'hffff, \
  16'h01ff, 16'hffff, 16'h1f00, 16'h0000, 16'h00ff, 16'h0038, 16'h03ff, 16'h0030}
`define CSU_STB_MAP {16'h0f00, 16'h3e00, 16'h0004, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h00ff, 16'hffff, 16'h0000, 16'h0047, 16'h0000, 16'h160f}
`define CSU_OTP_MAP {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h2000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h09c0}
`define CSU_GAIN_PATH_MAP {16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define CSU_VOL_MAP {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000f, 16'h0000}
`define CSU_SELF_CLR_MAP {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000}
`define CSU_ALIGN_MAP 14'b00000000000100

// reset values
`define CSU_RST_REG 16'h0000

`endif

// *** logic/csu_serial.v ***
// Purpose: serial frame front end, turns 24-bit frames into register strobes
// Assumes: serial pins synchronous to clk, serial clock at most clk/4
// Notes: bits sampled on the falling serial clock edge, msb first
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_serial (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // serial pins
  input wire scs_n,
  input wire sclk,
  input wire sdi,
  output wire sdo,
  output reg sdo_oe_n,
  // register strobes
  output reg [6:0] ser_addr,
  output reg [15:0] ser_wdata,
  output reg ser_wr,
  output reg ser_rd,
  input wire [15:0] rd_data
);

  reg sclk_q;
  reg [4:0] bit_cnt;
  reg [22:0] shreg;
  reg [15:0] out_sh;
  reg rd_wait;
  reg is_read;
  wire fall = sclk_q & ~sclk & ~scs_n;

  // frame shifter; a write frame with the select released early is dropped
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'h00;
      shreg <= 23'h000000;
      out_sh <= 16'h0000;
      rd_wait <= 1'b0;
      is_read <= 1'b0;
      ser_wr <= 1'b0;
      ser_rd <= 1'b0;
      ser_addr <= 7'h00;
      ser_wdata <= 16'h0000;
      sdo_oe_n <= 1'b1;
    end else begin
      sclk_q <= sclk;
      ser_wr <= 1'b0;
      ser_rd <= 1'b0;
      rd_wait <= ser_rd;
      if (rd_wait) begin
        out_sh <= rd_data; // read data loaded for the data phase
      end
      if (scs_n) begin
        bit_cnt <= 5'h00;
        is_read <= 1'b0;
        sdo_oe_n <= 1'b1;
      end else if (fall) begin
        shreg <= {shreg[21:0], sdi};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'h07 && shreg[6] == `CSU_CMD_READ) begin
          ser_rd <= 1'b1;
          ser_addr <= {shreg[5:0], sdi};
          is_read <= 1'b1;
          sdo_oe_n <= 1'b0;
        end
        if (bit_cnt >= 5'h08 && is_read) begin
          out_sh <= {out_sh[14:0], 1'b0};
        end
        if (bit_cnt == 5'h17 && shreg[22] == `CSU_CMD_WRITE) begin
          ser_wr <= 1'b1;
          ser_addr <= shreg[21:15];
          ser_wdata <= {shreg[14:0], sdi};
        end
      end
    end
  end

  assign sdo = out_sh[15];

endmodule

// *** logic/csu_field_reg.v ***
// Purpose: one configuration register, visible copy plus effective copy
// Assumes: class masks of one register do not overlap
// Notes: load_en takes the nonvolatile image after power-up
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_field_reg #(
  parameter [15:0] ALW = 16'h0000,
  parameter [15:0] STB = 16'h0000,
  parameter [15:0] OTP = 16'h0000,
  parameter [15:0] GAIN_PATH = 16'h0000,
  parameter [15:0] VOL = 16'h0000,
  parameter [15:0] SELF_CLR = 16'h0000,
  parameter ALIGN = 0
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // control
  input wire wr_en,
  input wire [15:0] wdata,
  input wire standby,
  input wire sync_ev,
  input wire load_en,
  input wire [15:0] load_data,
  // contents
  output reg [15:0] vis,
  output reg [15:0] eff
);

  reg pend;
  reg [15:0] next_eff;
  wire [15:0] new_vis = wr_en ? wdata : (vis & ~SELF_CLR);
  wire [15:0] image = load_data & ~VOL;

  // route the written value per class
  always @* begin
    next_eff = eff & ~SELF_CLR;
    if (ALIGN == 0) begin
      if (wr_en) begin
        next_eff = (next_eff & ~ALW) | (wdata & ALW);
      end
    end else if (sync_ev && (pend || wr_en)) begin
      next_eff = (next_eff & ~ALW) | (new_vis & ALW);
    end
    if (standby) begin
      next_eff = (next_eff & ~STB) | (new_vis & STB);
      next_eff = next_eff & ~(GAIN_PATH & ~new_vis);
    end
  end

  // otp bits of eff change only on load; vis takes writes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vis <= `CSU_RST_REG;
      eff <= `CSU_RST_REG;
      pend <= 1'b0;
    end else if (load_en) begin
      vis <= image;
      eff <= image;
      pend <= 1'b0;
    end else begin
      vis <= new_vis;
      eff <= next_eff;
      if (ALIGN != 0) begin
        pend <= (wr_en && !sync_ev) || (pend && !sync_ev);
      end
    end
  end

endmodule

// *** logic/csu_top.v ***
// Purpose: configuration shadow and update control of a gate driver
// Assumes: nonvolatile macro answers a read one cycle after its address
// Notes: standby follows the drive enable input; registers blocked until loaded
// How it works
// - writes to any configuration field are taken at any time once loading ends.
// - always-class bits outside the pwm configuration register reach the effective copy the cycle after the write.
// - the pwm configuration register applies its always bits on a pwm or brake event.
// - standby-class bits reach the effective copy only in standby, which follows drive enable low one cycle later.
// - reads return the last written value even while it is still pending, except the self-clearing converter request bit.
// - pending standby bits are copied on entry to standby and while in it.
// - otp-class bits of the effective copy change only from the nonvolatile image loaded at power-up.
// - the nonvolatile image is read after reset release, before any access.
// - the nv program command starts programming only in standby.
// - the gain path bit goes to digital in standby, to analog only from the image.
// - converter request, input select and filter enable are volatile only.
// - serial frames are 24 bits: command, 7-bit address, 16 data bits, msb first.
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_top #(
  parameter NREG = `CSU_NREG
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // plain register port
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // serial pins
  input wire scs_n,
  input wire sclk,
  input wire sdi,
  output wire sdo,
  output wire sdo_oe_n,
  // device state and alignment events
  input wire drive_enable_input,
  input wire pwm_edge,
  input wire brake_event,
  // nonvolatile memory macro
  output reg [3:0] nv_addr,
  input wire [15:0] nv_rd_data,
  output reg nv_program_command,
  input wire nv_busy,
  // effective configuration and status
  output wire [16*NREG-1:0] cfg_eff,
  output wire conv_on_demand_request,
  output wire in_standby,
  output wire loaded
);

  localparam ST_STANDBY = 1'b0;
  localparam ST_ACTIVE = 1'b1;
  localparam [16*NREG-1:0] ALW_MAP = `CSU_ALW_MAP;
  localparam [16*NREG-1:0] STB_MAP = `CSU_STB_MAP;
  localparam [16*NREG-1:0] OTP_MAP = `CSU_OTP_MAP;
  localparam [16*NREG-1:0] GAIN_MAP = `CSU_GAIN_PATH_MAP;
  localparam [16*NREG-1:0] VOL_MAP = `CSU_VOL_MAP;
  localparam [16*NREG-1:0] SELF_MAP = `CSU_SELF_CLR_MAP;
  localparam [NREG-1:0] ALIGN_MAP = `CSU_ALIGN_MAP;

  reg state;
  reg next_state;
  reg [4:0] load_cnt;
  reg load_done;
  reg load_valid;
  reg [3:0] load_index;
  reg prog_refused;
  reg [7:0] user_id;
  wire [6:0] ser_addr;
  wire [15:0] ser_wdata;
  wire ser_wr;
  wire ser_rd;
  wire [16*NREG-1:0] vis_all;

  // true when an address falls in the configuration window
  function is_cfg;
    input [6:0] a;
    begin
      is_cfg = (a >= `CSU_ADDR_CFG_FIRST) && (a <= `CSU_ADDR_CFG_LAST);
    end
  endfunction

  // the plain port wins when both paths strobe in one cycle
  wire use_plain = reg_wr | reg_rd;
  wire [6:0] acc_addr = use_plain ? reg_addr : ser_addr;
  wire [15:0] acc_wdata = reg_wr ? reg_wdata : ser_wdata;
  wire acc_wr = (reg_wr | (ser_wr & ~reg_rd)) & load_done;
  wire acc_rd = (reg_rd | (ser_rd & ~reg_wr)) & load_done;
  wire [6:0] cfg_index = acc_addr - `CSU_ADDR_CFG_FIRST;
  wire sync_ev = pwm_edge | brake_event;

  assign in_standby = (state == ST_STANDBY);
  assign loaded = load_done;

  // device state follows the drive enable input
  always @* begin
    next_state = state;
    case (state)
      ST_STANDBY: begin
        if (drive_enable_input) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!drive_enable_input) begin
          next_state = ST_STANDBY;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // power-up loader walks the image one register per cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_cnt <= 5'h00;
      load_done <= 1'b0;
      load_valid <= 1'b0;
      load_index <= 4'h0;
      nv_addr <= 4'h0;
    end else begin
      load_valid <= 1'b0;
      if (!load_done) begin
        if (load_cnt < NREG[4:0]) begin
          nv_addr <= load_cnt[3:0];
          load_index <= nv_addr;
          load_valid <= (load_cnt != 5'h00);
          load_cnt <= load_cnt + 5'h01;
        end else begin
          load_index <= nv_addr;
          load_valid <= 1'b1;
          load_done <= 1'b1;
        end
      end
    end
  end

  // one slice per register, class chosen from the constant maps
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      csu_field_reg #(
        .ALW(ALW_MAP[16*gi +: 16]),
        .STB(STB_MAP[16*gi +: 16]),
        .OTP(OTP_MAP[16*gi +: 16]),
        .GAIN_PATH(GAIN_MAP[16*gi +: 16]),
        .VOL(VOL_MAP[16*gi +: 16]),
        .SELF_CLR(SELF_MAP[16*gi +: 16]),
        .ALIGN(ALIGN_MAP[gi])
      ) u_reg (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(acc_wr && is_cfg(acc_addr) && (cfg_index == gi)),
        .wdata(acc_wdata),
        .standby(in_standby),
        .sync_ev(sync_ev),
        .load_en(load_valid && (load_index == gi)),
        .load_data(nv_rd_data),
        .vis(vis_all[16*gi +: 16]),
        .eff(cfg_eff[16*gi +: 16])
      );
    end
  endgenerate

  // converter request is a one-cycle pulse from its self-clearing bit
  assign conv_on_demand_request = cfg_eff[16*`CSU_ADC_INDEX + `CSU_ADC_REQ_BIT];

  // nv program command and user id; programming refused outside standby
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nv_program_command <= 1'b0;
      prog_refused <= 1'b0;
      user_id <= 8'h00;
    end else begin
      nv_program_command <= 1'b0;
      if (acc_wr && acc_addr == `CSU_ADDR_NV_PROG) begin
        user_id <= acc_wdata[15:8];
        if (acc_wdata[`CSU_NVP_CMD_BIT]) begin
          if (in_standby && !nv_busy) begin
            nv_program_command <= 1'b1;
            prog_refused <= 1'b0;
          end else begin
            prog_refused <= 1'b1;
          end
        end
      end
    end
  end

  // read data stands one cycle after the strobe; unmapped reads return zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (acc_rd) begin
      if (is_cfg(acc_addr)) begin
        reg_rdata <= vis_all[16*cfg_index[3:0] +: 16];
      end else if (acc_addr == `CSU_ADDR_NV_PROG) begin
        reg_rdata <= {user_id, 8'h00}; // command bit is write only
      end else if (acc_addr == `CSU_ADDR_FUNC_ST) begin
        reg_rdata <= {12'h000, nv_busy, prog_refused, load_done, in_standby};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // serial frame front end
  csu_serial u_serial (
    .clk(clk),
    .arst_n(arst_n),
    .scs_n(scs_n),
    .sclk(sclk),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .ser_addr(ser_addr),
    .ser_wdata(ser_wdata),
    .ser_wr(ser_wr),
    .ser_rd(ser_rd),
    .rd_data(reg_rdata)
  );

endmodule

// *** tb/csu_top_checker.sv ***
// Purpose: port-level checks of the configuration shadow block
// Assumes: class maps and addresses as in csu_defines.vh
// Notes: attached to csu_top by bind at the foot of this file
`timescale 1ns/1ps

module csu_top_checker #(
  parameter NREG = 14
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // register port
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // state, events and nv macro
  input wire drive_enable_input,
  input wire nv_busy,
  input wire nv_program_command,
  // effective configuration and status
  input wire [16*NREG-1:0] cfg_eff,
  input wire conv_on_demand_request,
  input wire in_standby,
  input wire loaded
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  read_slot_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its slot");
  standby_entry_a: assert property ($fell(drive_enable_input) |=> in_standby)
    else $error("standby not entered after drive enable fell");
  nv_prog_gate_a: assert property (nv_program_command |-> $past(in_standby) && !$past(nv_busy))
    else $error("nv programming started outside standby");
  nv_prog_pulse_a: assert property (nv_program_command |=> !nv_program_command)
    else $error("nv program command longer than one cycle");
  conv_req_a: assert property (reg_wr && loaded && reg_addr == 7'h12 && reg_wdata[0]
    |=> conv_on_demand_request)
    else $error("conversion request not issued");
  conv_req_clear_a: assert property (conv_on_demand_request |=> !conv_on_demand_request)
    else $error("conversion request did not self clear");
  always_now_a: assert property (reg_wr && loaded && reg_addr == 7'h1e
    |=> (cfg_eff[16*13 +: 16] & 16'h70ff) == ($past(reg_wdata) & 16'h70ff))
    else $error("always bits not applied after write");
  standby_hold_a: assert property ($past(loaded) && !$past(in_standby)
    |-> $stable(cfg_eff[16*13 +: 16] & 16'h0f00))
    else $error("standby bits changed while active");
  gain_analog_a: assert property ($past(loaded) |-> !$rose(cfg_eff[16*12+3]))
    else $error("gain path went analog by a write");
endmodule

bind csu_top csu_top_checker #(.NREG(NREG)) i_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .drive_enable_input(drive_enable_input), .nv_busy(nv_busy),
  .nv_program_command(nv_program_command), .cfg_eff(cfg_eff),
  .conv_on_demand_request(conv_on_demand_request), .in_standby(in_standby),
  .loaded(loaded)
);

// *** tb/csu_spi_master.sv ***
// Purpose: microcontroller model sending one 24-bit serial frame
// Assumes: each serial clock level lasts two clk cycles
// Notes: data changes on rising sclk, device takes it on falling sclk
`timescale 1ns/1ps

module csu_spi_master (
  // clock
  input wire clk,
  // frame request
  input wire go,
  input wire [23:0] frame,
  output reg done,
  // serial pins
  output reg scs_n,
  output reg sclk,
  output reg sdi
);
  integer i;

  // idle levels before the first frame
  initial begin
    scs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    done = 1'b0;
  end

  // command, address, data, msb first; sclk stands still outside frames
  always @(posedge clk) begin
    if (go) begin
      scs_n <= 1'b0;
      for (i = 23; i >= 0; i = i - 1) begin
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        sdi <= frame[i];
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
      end
      repeat (2) @(posedge clk);
      scs_n <= 1'b1;
      sdi <= ~sdi; // released line shows no stale bit
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
  end
endmodule

// *** tb/test_config_shadow_update_control.sv ***
// Purpose: self-checking bench of the configuration shadow block
// Assumes: nv image reads all ones, so loaded bits start at one
// Notes: random data from a fixed lfsr seed
`timescale 1ns/1ps

module test_config_shadow_update_control;
  reg clk, arst_n, reg_wr, reg_rd, de, pwm_edge, brake_event, nv_busy, go;
  reg [6:0] reg_addr;
  reg [15:0] reg_wdata, rv, d, e;
  reg [23:0] frame;
  reg [31:0] seed;
  wire [15:0] reg_rdata;
  wire [223:0] cfg_eff;
  wire [3:0] nv_addr;
  wire scs_n, sclk, sdi, sdo, sdo_oe_n, nv_cmd, conv_req, in_standby, loaded, done;
  integer failures, num_checks, npulse, nreq, k;

  csu_top i_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scs_n(scs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .drive_enable_input(de), .pwm_edge(pwm_edge), .brake_event(brake_event),
    .nv_addr(nv_addr), .nv_rd_data(16'hffff), .nv_program_command(nv_cmd),
    .nv_busy(nv_busy), .cfg_eff(cfg_eff), .conv_on_demand_request(conv_req),
    .in_standby(in_standby), .loaded(loaded)
  );

  csu_spi_master i_spi (
    .clk(clk), .go(go), .frame(frame), .done(done), .scs_n(scs_n), .sclk(sclk), .sdi(sdi)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count one-cycle pulses leaving the block
  always @(posedge clk) begin
    if (nv_cmd === 1'b1) npulse <= npulse + 1;
    if (conv_req === 1'b1) nreq <= nreq + 1;
  end

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // supply register after standby copy: standby and always from d, otp from image
  function [15:0] exp_sup(input [15:0] v);
    exp_sup = (v & 16'h163f) | 16'h09c0;
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task wr(input [6:0] a, input [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(negedge clk);
    end
  endtask

  task rd(input [6:0] a, output [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
    end
  endtask

  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  // watchdog
  initial begin
    cyc(20000);
    failures = failures + 1;
    close_out;
  end

  initial begin
    {arst_n, reg_wr, reg_rd, de, pwm_edge, brake_event, nv_busy, go} = 8'h00;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    frame = 24'h000000;
    failures = 0;
    num_checks = 0;
    npulse = 0;
    nreq = 0;
    seed = 32'h22827d85;
    cyc(4);
    arst_n <= 1'b1;
    k = 0;
    while (loaded !== 1'b1 && k < 40) begin
      @(negedge clk);
      k = k + 1;
    end
    chk(cfg_eff[15:0] & 16'h1fff, 16'h1fff);
    // active writes apply always bits at once, standby bits stay pending until standby entry copies them
    e = 16'h1fff;
    for (k = 0; k < 4; k = k + 1) begin
      seed = lfsr(seed);
      d = seed[15:0];
      de <= 1'b1;
      cyc(2);
      wr(7'h11, d);
      e = (e & 16'h1fcf) | (d & 16'h0030);
      chk(cfg_eff[15:0] & 16'h1fff, e);
      rd(7'h11, rv);
      chk(rv, d);
      de <= 1'b0;
      cyc(3);
      @(negedge clk);
      e = exp_sup(d);
      chk(cfg_eff[15:0] & 16'h1fff, e);
    end
    wr(7'h11, 16'h0000);
    chk(cfg_eff[15:0] & 16'h1fff, 16'h09c0);
    // gain path: digital only in standby, never back to analog
    de <= 1'b1;
    wr(7'h1d, 16'h0000);
    chk(cfg_eff[195], 1);
    // second amplifier register: always bits now, standby bits pending
    seed = lfsr(seed);
    d = seed[15:0];
    wr(7'h1e, d);
    chk(cfg_eff[223:208] & 16'h7fff, (d & 16'h70ff) | 16'h0f00);
    de <= 1'b0;
    cyc(3);
    chk(cfg_eff[223:208] & 16'h7fff, d & 16'h7fff);
    chk(in_standby, 1'b1);
    wr(7'h1d, 16'h0008);
    chk(cfg_eff[195], 0);
    // pwm register always bits wait for a pwm or brake event
    wr(7'h13, 16'h0000);
    chk(cfg_eff[37:35], 3'h7);
    pwm_edge <= 1'b1;
    cyc(1);
    pwm_edge <= 1'b0;
    @(negedge clk);
    chk(cfg_eff[37:35], 3'h0);
    wr(7'h13, 16'h0038);
    brake_event <= 1'b1;
    cyc(1);
    brake_event <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(cfg_eff[37:35], 3'h7);
    // nv program refused while active or busy, taken in standby
    de <= 1'b1;
    cyc(2);
    wr(7'h1f, 16'h0001);
    rd(7'h03, rv);
    chk(rv[2], 1);
    de <= 1'b0;
    nv_busy <= 1'b1;
    cyc(3);
    wr(7'h1f, 16'h0001);
    nv_busy <= 1'b0;
    wr(7'h1f, 16'h0001);
    cyc(2);
    chk(npulse, 1);
    wr(7'h12, 16'h0001);
    cyc(2);
    chk(nreq, 1);
    rd(7'h40, rv);
    chk(rv, 16'h0000);
    // serial write of always bits in active state
    de <= 1'b1;
    seed = lfsr(seed);
    d = seed[15:0];
    frame <= {1'b1, 7'h1b, d};
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k = k + 1;
    end
    cyc(3);
    @(negedge clk);
    chk(cfg_eff[167:160] & 8'hff, d[7:0]);
    chk(cfg_eff[167:160], d[7:0]);
    chk(sdo_oe_n, 1'b1);
    close_out;
  end
endmodule
